// ### src/uart_modem_control_loopback.sv
// Modem control register, loopback routing and modem-change interrupts
//
// Overview of operation
// - DTR pin low while bit 0 set, outside loopback
// - RTS pin low while bit 1 set, outside loopback
// - Bit 2 is storage, loops to ring
// - Bit 3 enables interrupt pin, else released
// - Loopback holds transmit pin at mark
// - Loopback ignores external receive pin
// - Loopback feeds transmit shift into receiver
// - Loopback disconnects modem input pins
// - Loopback maps control bits onto modem inputs
// - Loopback forces modem output pins high
// - Receive and transmit interrupts unchanged in loopback
// - Loopback modem interrupts come from control bits
`timescale 1ns/100ps
module uart_modem_control_loopback
   import mlc_pkg::*;
#(
   parameter int ADDR_W = 8  // Avalon byte address width
) (
   input  wire logic              CLK,
   input  wire logic              RST_B,
   input  wire logic [ADDR_W-1:0] ADDRESS,
   input  wire logic              READ,
   input  wire logic              WRITE,
   input  wire logic [31:0]       WRITEDATA,
   input  wire logic [3:0]        BYTEENABLE,
   output logic [31:0]            READDATA,
   output logic                   WAITREQUEST,
   input  wire logic              TX_SHIFT_OUT,
   input  wire logic              RXD_PIN,
   output logic                   TXD_PIN,
   output logic                   RX_SHIFT_IN,
   input  wire logic              CTS_N,
   input  wire logic              DSR_N,
   input  wire logic              RI_N,
   input  wire logic              DCD_N,
   output logic                   DTR_N,
   output logic                   RTS_N,
   output logic [3:0]             MODEM_IN,
   input  wire logic              MODEM_IRQ_EN,
   output logic                   MODEM_INT_REQ,
   input  wire logic              UART_INT_REQ,
   output logic                   IRQ_PIN_O,
   output logic                   IRQ_PIN_OE,
   output logic                   INTR
);
   import mlc_pkg::*;

   // Refuse an address bus too narrow for the map
   if (ADDR_W < 5) begin : g_addr_check
      $error("ADDR_W must be at least 5");
   end

   // Control register and derived state
   logic [MLC_W-1:0]   mlc_reg;        // Modem line control
   logic [MODEM_W-1:0] modem_in_reg;   // Internal modem inputs
   logic [MODEM_W-1:0] modem_in_next;  // Next internal modem inputs
   logic [MODEM_W-1:0] delta;          // Lines that change this edge
   logic [MODEM_W-1:0] irq_stat_reg;   // Sticky change flags
   logic [MODEM_W-1:0] irq_mask_reg;   // Interrupt mask
   logic               loop_on;        // Loopback active

   // Bus decode
   logic               req;            // Request present
   logic               take;           // Request completes this edge
   logic               wr_take;        // Write completes
   logic               rd_take;        // Read completes
   logic               hit_mlc;        // Control register selected
   logic               hit_stat;       // Status register selected
   logic               hit_mask;       // Mask register selected
   logic               hit_modem;      // Modem view selected
   logic [31:0]        rd_value;       // Read mux result

   assign loop_on  = mlc_reg[LOOP_BIT];
   assign req      = READ | WRITE;
   // Completion is the edge on which waitrequest stands low
   assign take     = req & ~WAITREQUEST;
   assign wr_take  = take & WRITE & BYTEENABLE[0];
   assign rd_take  = take & READ;
   assign hit_mlc   = (ADDRESS == ADDR_W'(MLC_OFS));
   assign hit_modem = (ADDRESS == ADDR_W'(MODEM_ST_OFS));
   assign hit_stat  = (ADDRESS == ADDR_W'(IRQ_STAT_OFS));
   assign hit_mask  = (ADDRESS == ADDR_W'(IRQ_MASK_OFS));

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_value = 32'h0000_0000;
      if (hit_mlc) begin
         // Reserved bits above the field stay zero
         rd_value = {27'h0000000, mlc_reg};
      end else if (hit_modem) begin
         rd_value = {28'h0000000, modem_in_reg};
      end else if (hit_stat) begin
         rd_value = {28'h0000000, irq_stat_reg};
      end else if (hit_mask) begin
         rd_value = {28'h0000000, irq_mask_reg};
      end
   end

   // Waitrequest: one wait state, then low for exactly one edge
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         WAITREQUEST <= 1'b1;
      end else if (req && WAITREQUEST) begin
         // Accept: answer on the next edge
         WAITREQUEST <= 1'b0;
      end else begin
         // Done or idle: back to stalling
         WAITREQUEST <= 1'b1;
      end
   end

   // Read data latched when the answer is prepared
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         READDATA <= 32'h0000_0000;
      end else if (req && WAITREQUEST) begin
         READDATA <= rd_value;
      end
   end

   // Control register; writes to unmapped space are dropped
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         mlc_reg <= MLC_RST;
      end else if (wr_take && hit_mlc) begin
         // Bits 7:5 are never stored
         mlc_reg <= WRITEDATA[MLC_W-1:0];
      end
   end

   // Mask register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         irq_mask_reg <= IRQ_MASK_RST;
      end else if (wr_take && hit_mask) begin
         irq_mask_reg <= WRITEDATA[MODEM_W-1:0];
      end
   end

   // Source select for the internal modem inputs
   always_comb begin
      if (loop_on) begin
         // Pins ignored; control bits stand in
         modem_in_next[DSR_POS] = mlc_reg[DTR_BIT];
         modem_in_next[CTS_POS] = mlc_reg[RTS_BIT];
         modem_in_next[RI_POS]  = mlc_reg[SPARE_BIT];
         modem_in_next[DCD_POS] = mlc_reg[IRQOE_BIT];
      end else begin
         // Pins are active low
         modem_in_next[CTS_POS] = ~CTS_N;
         modem_in_next[DSR_POS] = ~DSR_N;
         modem_in_next[RI_POS]  = ~RI_N;
         modem_in_next[DCD_POS] = ~DCD_N;
      end
   end

   // Change detect per line, whichever source is live
   assign delta = modem_in_next ^ modem_in_reg;

   // Internal modem inputs held for the modem status logic
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         modem_in_reg <= MODEM_RST;
      end else begin
         modem_in_reg <= modem_in_next;
      end
   end

   // Sticky flags; a change in the clearing edge survives the read
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         irq_stat_reg <= IRQ_STAT_RST;
      end else if (rd_take && hit_stat) begin
         irq_stat_reg <= delta;
      end else begin
         irq_stat_reg <= irq_stat_reg | delta;
      end
   end

   // Modem-change request to the port's interrupt logic
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         MODEM_INT_REQ <= 1'b0;
      end else begin
         // Still gated by the interrupt enable register
         MODEM_INT_REQ <= (|irq_stat_reg) & MODEM_IRQ_EN;
      end
   end

   // Local interrupt from unmasked sticky flags
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         INTR <= 1'b0;
      end else begin
         INTR <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Modem output pins; inactive high in loopback
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         DTR_N <= 1'b1;
         RTS_N <= 1'b1;
      end else begin
         DTR_N <= loop_on | ~mlc_reg[DTR_BIT];
         RTS_N <= loop_on | ~mlc_reg[RTS_BIT];
      end
   end

   // Serial path; one flop on each leg keeps both ends aligned
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         TXD_PIN     <= 1'b1;
         RX_SHIFT_IN <= 1'b1;
      end else begin
         // Mark while looping, whatever the transmitter does
         TXD_PIN     <= loop_on | TX_SHIFT_OUT;
         // External receive pin not sampled in loopback
         RX_SHIFT_IN <= loop_on ? TX_SHIFT_OUT : RXD_PIN;
      end
   end

   // Interrupt pin; released when the enable bit is clear
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ_PIN_O  <= 1'b0;
         IRQ_PIN_OE <= 1'b0;
      end else begin
         // Receive and transmit requests pass whatever the mode
         IRQ_PIN_O  <= UART_INT_REQ;
         IRQ_PIN_OE <= mlc_reg[IRQOE_BIT];
      end
   end

   // Modem inputs to the status logic
   assign MODEM_IN = modem_in_reg;

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   logic acc_mlc;  // Control write completing
   assign acc_mlc = wr_take & hit_mlc;

   a_dtr_pin_drive: assert property (
      acc_mlc && !WRITEDATA[LOOP_BIT] |=> ##1 DTR_N == !$past(WRITEDATA[DTR_BIT], 2)
   ) else $error("DTR pin does not follow bit 0");

   a_rts_pin_drive: assert property (
      acc_mlc && !WRITEDATA[LOOP_BIT] |=> ##1 RTS_N == !$past(WRITEDATA[RTS_BIT], 2)
   ) else $error("RTS pin does not follow bit 1");

   a_spare_bit_store: assert property (
      acc_mlc |=> mlc_reg[SPARE_BIT] == $past(WRITEDATA[SPARE_BIT])
   ) else $error("Spare bit not stored");

   a_irq_pin_gate: assert property (
      acc_mlc |=> ##1 IRQ_PIN_OE == $past(WRITEDATA[IRQOE_BIT], 2)
   ) else $error("Interrupt pin enable wrong");

   a_txd_mark_loop: assert property (
      loop_on |=> TXD_PIN
   ) else $error("Transmit pin not marking in loopback");

   a_rx_source_sel: assert property (
      1'b1 |=> RX_SHIFT_IN == ($past(loop_on) ? $past(TX_SHIFT_OUT) : $past(RXD_PIN))
   ) else $error("Receiver input from wrong source");

   a_tx_rx_loop: assert property (
      loop_on && $stable(loop_on) && !TX_SHIFT_OUT |=> !RX_SHIFT_IN && TXD_PIN
   ) else $error("Transmitted bit not looped back");

   a_modem_pins_cut: assert property (
      loop_on && !$changed(mlc_reg) |=> $stable(MODEM_IN)
   ) else $error("Modem pins leak into loopback");

   a_modem_loop_map: assert property (
      loop_on |=> MODEM_IN == {$past(mlc_reg[IRQOE_BIT]), $past(mlc_reg[SPARE_BIT]),
                               $past(mlc_reg[DTR_BIT]), $past(mlc_reg[RTS_BIT])}
   ) else $error("Loopback modem mapping wrong");

   a_outputs_inactive: assert property (
      loop_on |=> DTR_N && RTS_N
   ) else $error("Modem pins not inactive in loopback");

   a_irq_pass_loop: assert property (
      loop_on |=> IRQ_PIN_O == $past(UART_INT_REQ)
   ) else $error("Interrupt source blocked in loopback");

   a_change_sets_flag: assert property (
      $changed(modem_in_reg) |-> ((modem_in_reg ^ $past(modem_in_reg)) & ~irq_stat_reg) == 4'h0
   ) else $error("Modem change lost");

   a_modem_req_gate: assert property (
      !MODEM_IRQ_EN |=> !MODEM_INT_REQ
   ) else $error("Modem request not gated");

   a_reserved_zero: assert property (
      req && WAITREQUEST && hit_mlc |=> READDATA[31:MLC_W] == '0
   ) else $error("Reserved bits read nonzero");

   // Bus handshake: one wait state, then waitrequest low for one edge only
   a_wait_one_state: assert property (
      req && WAITREQUEST |=> !WAITREQUEST
   ) else $error("Waitrequest did not fall after one wait state");

   a_wait_one_cycle: assert property (
      !WAITREQUEST |=> WAITREQUEST
   ) else $error("Waitrequest low for more than one cycle");

   // Whole writable field lands; bits 7:5 have no storage at all
   a_mlc_store: assert property (
      acc_mlc |=> mlc_reg == $past(WRITEDATA[MLC_W-1:0])
   ) else $error("Control field not stored");

   // Status read with no change in that edge leaves nothing behind
   a_stat_clear: assert property (
      rd_take && hit_stat && delta == 4'h0 |=> irq_stat_reg == 4'h0
   ) else $error("Status read did not clear");

   // Set wins: a change in the clearing edge must not be lost
   a_stat_set_wins: assert property (
      rd_take && hit_stat |=> (irq_stat_reg & $past(delta)) == $past(delta)
   ) else $error("Change lost in clearing edge");

   // Enabled flags reach the port's interrupt logic one edge later
   a_mreq_follow: assert property (
      MODEM_IRQ_EN && (|irq_stat_reg) |=> MODEM_INT_REQ
   ) else $error("Modem request missing while enabled");

   // All flags masked keeps the local interrupt quiet
   a_intr_masked: assert property (
      irq_mask_reg == 4'h0 |=> !INTR
   ) else $error("Interrupt raised with all flags masked");

   // Outside loopback the transmit pin is the shifter, one edge late
   a_txd_follow: assert property (
      !loop_on |=> TXD_PIN == $past(TX_SHIFT_OUT)
   ) else $error("Transmit pin does not follow shifter");

   // Main scenarios
   c_loop_entry: cover property (acc_mlc && WRITEDATA[LOOP_BIT]);
   c_loop_change_irq: cover property (loop_on && |delta ##2 MODEM_INT_REQ);
   c_read_clear: cover property (rd_take && hit_stat && |irq_stat_reg);
   c_intr_rise: cover property (!INTR ##1 INTR);
   c_loop_tx_zero: cover property (loop_on && !TX_SHIFT_OUT ##1 !RX_SHIFT_IN);
endmodule

// ### src/mlc_pkg.sv
// Register map, field positions and reset values of the modem control block
package mlc_pkg;
   // Register byte addresses
   localparam logic [7:0] MLC_OFS       = 8'h04;  // Modem line control
   localparam logic [7:0] MODEM_ST_OFS  = 8'h08;  // Internal modem inputs
   localparam logic [7:0] IRQ_STAT_OFS  = 8'h0c;  // Sticky change flags
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;  // Interrupt mask
   // Control field positions
   localparam int DTR_BIT    = 0;  // Data terminal ready
   localparam int RTS_BIT    = 1;  // Request to send
   localparam int SPARE_BIT  = 2;  // spare_user_output
   localparam int IRQOE_BIT  = 3;  // irq_output_enable
   localparam int LOOP_BIT   = 4;  // Loopback mode
   localparam int MLC_W      = 5;  // Writable width
   // Internal modem input positions (true sense)
   localparam int CTS_POS    = 0;
   localparam int DSR_POS    = 1;
   localparam int RI_POS     = 2;
   localparam int DCD_POS    = 3;
   localparam int MODEM_W    = 4;
   // Reset values
   localparam logic [MLC_W-1:0]   MLC_RST      = 5'h00;
   localparam logic [MODEM_W-1:0] MODEM_RST    = 4'h0;
   localparam logic [MODEM_W-1:0] IRQ_STAT_RST = 4'h0;
   localparam logic [MODEM_W-1:0] IRQ_MASK_RST = 4'h0;
endpackage

// ### testbench/modem_model.sv
// Modem partner: answers the control lines and drives the receive line
`timescale 1ns/100ps
module modem_model #(
   parameter int LAG = 2  // Answer delay in cycles, at least 2
) (
   input  wire logic CLK,
   input  wire logic DTR_N,
   input  wire logic RTS_N,
   input  wire logic CARRIER,
   input  wire logic NOISE,
   output logic      CTS_N,
   output logic      DSR_N,
   output logic      RI_N,
   output logic      DCD_N,
   output logic      RXD_PIN
);
   logic [LAG-1:0] cts_dly = '1;  // Clear-to-send pipeline, idle inactive
   logic [LAG-1:0] dsr_dly = '1;  // Data-set-ready pipeline
   // Handshakes answer late; noise toggles the line so a stale sample shows
   always @(posedge CLK) begin
      cts_dly <= {cts_dly[LAG-2:0], RTS_N};
      dsr_dly <= {dsr_dly[LAG-2:0], DTR_N};
      RXD_PIN <= NOISE ? ~RXD_PIN : 1'b1;
   end
   initial RXD_PIN = 1'b1;
   assign CTS_N = cts_dly[LAG-1];
   assign DSR_N = dsr_dly[LAG-1];
   assign RI_N  = 1'b1;  // No ring from this modem
   assign DCD_N = ~CARRIER;
endmodule

// ### testbench/test_uart_modem_control_loopback.sv
// Self-checking bench for modem control, loopback and modem interrupts
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module test_uart_modem_control_loopback;
   import mlc_pkg::*;
   logic        clk = 0, rst_b = 0, rd = 0, wr = 0, tx_so = 1, irq_en = 0, uirq = 0;
   logic        carrier = 0, noise = 0, rxd, txd, rx_si, cts_n, dsr_n, ri_n, dcd_n;
   logic        dtr_n, rts_n, mreq, pin_o, pin_oe, intr, wait_req;
   logic [7:0]  addr = 0;
   logic [31:0] wdata = 0, rdata, q;
   logic [3:0]  modem_in;
   int          n_fail = 0, n_checks = 0;
   always #12.5 clk = ~clk;  // 40 MHz
   uart_modem_control_loopback dut (.CLK(clk), .RST_B(rst_b), .ADDRESS(addr), .READ(rd),
      .WRITE(wr), .WRITEDATA(wdata), .BYTEENABLE(4'hf), .READDATA(rdata),
      .WAITREQUEST(wait_req), .TX_SHIFT_OUT(tx_so), .RXD_PIN(rxd), .TXD_PIN(txd),
      .RX_SHIFT_IN(rx_si), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n), .DCD_N(dcd_n),
      .DTR_N(dtr_n), .RTS_N(rts_n), .MODEM_IN(modem_in), .MODEM_IRQ_EN(irq_en),
      .MODEM_INT_REQ(mreq), .UART_INT_REQ(uirq), .IRQ_PIN_O(pin_o), .IRQ_PIN_OE(pin_oe),
      .INTR(intr));
   modem_model #(.LAG(2)) peer (.CLK(clk), .DTR_N(dtr_n), .RTS_N(rts_n), .CARRIER(carrier),
      .NOISE(noise), .CTS_N(cts_n), .DSR_N(dsr_n), .RI_N(ri_n), .DCD_N(dcd_n),
      .RXD_PIN(rxd));
   // Counts and verdict, the only exit
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One Avalon cycle; holds the request until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wait_req === 1'b0) break;
      end
      if (i == 20) begin
         n_fail++;
         test_done();
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Let registered outputs land before looking
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Reset values, reserved bits, unmapped place
   task automatic t_regs();
      bus(0, MLC_OFS, 0);
      `CHK(q, 32'h0)
      `CHK({dtr_n, rts_n, pin_oe, txd}, 4'b1101)
      bus(1, MLC_OFS, 32'hffff_ffff);
      bus(0, MLC_OFS, 0);
      `CHK(q, 32'h0000_001f)
      bus(1, 8'h20, 32'hffff_ffff);
      bus(0, 8'h20, 0);
      `CHK(q, 32'h0)
   endtask
   // Normal mode: outputs follow the bits, modem answers reach the inputs
   task automatic t_normal();
      bus(1, MLC_OFS, 32'h0000_0003);
      tx_so <= 1'b0;
      settle(6);
      `CHK({dtr_n, rts_n}, 2'b00)
      `CHK(modem_in, 4'h3)
      `CHK(pin_oe, 1'b0)
      `CHK({txd, rx_si}, 2'b01)
      bus(1, MLC_OFS, 32'h0000_0008);
      settle(2);
      `CHK({dtr_n, rts_n, pin_oe}, 3'b111)
   endtask
   // Loopback: pins forced, inputs come from the control bits
   task automatic t_loop();
      @(posedge clk);
      carrier <= 1'b1;
      noise <= 1'b1;
      bus(1, MLC_OFS, 32'h0000_0014);
      settle(5);
      `CHK(modem_in, 4'h4)
      bus(1, MLC_OFS, 32'h0000_001b);
      settle(2);
      `CHK({txd, dtr_n, rts_n, pin_oe}, 4'b1111)
      `CHK(modem_in, 4'hb)
      bus(0, MODEM_ST_OFS, 0);
      `CHK(q, 32'h0000_000b)
      repeat (2) begin
         @(posedge clk);
         tx_so <= ~tx_so;
         settle(2);
         `CHK(rx_si, tx_so)
      end
      @(posedge clk);
      uirq <= 1'b1;
      settle(2);
      `CHK(pin_o, 1'b1)
   endtask
   // Loopback interrupts from control bit changes, masked and cleared
   task automatic t_irq();
      @(posedge clk);
      irq_en <= 1'b1;
      bus(1, IRQ_MASK_OFS, 32'h0000_0004);
      bus(0, IRQ_MASK_OFS, 0);
      `CHK(q, 32'h0000_0004)
      bus(0, IRQ_STAT_OFS, 0);
      settle(3);
      `CHK({intr, mreq}, 2'b00)
      bus(1, MLC_OFS, 32'h0000_001f);
      settle(4);
      `CHK({intr, mreq}, 2'b11)
      bus(0, IRQ_STAT_OFS, 0);
      `CHK(q[3:0], 4'h4)
      settle(3);
      `CHK({intr, mreq}, 2'b00)
      bus(1, MLC_OFS, 32'h0000_001d);
      settle(4);
      `CHK({intr, mreq}, 2'b01)
      @(posedge clk);
      irq_en <= 1'b0;
      settle(3);
      `CHK(mreq, 1'b0)
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_normal();
      t_loop();
      t_irq();
      test_done();
   end
endmodule
